// [logic/sram_port_map.svh]
// constant map: widths, organisations and mode-pin defaults of the burst memory port
`ifndef SRAM_PORT_MAP_SVH
`define SRAM_PORT_MAP_SVH

// ==========================================================
// organisation: one byte lane is eight data bits plus one parity bit
`define LANE_W          9
`define BURST_W         2
`define ADDR_W_X36      18
`define DATA_W_X36      36
`define ADDR_W_X18      19
`define DATA_W_X18      18

// ==========================================================
// levels that the internal pull resistors give a floating mode pin; DEF_PARITY_ODD is only the reset parity setting
`define DEF_FLOW_N      1'b1
`define DEF_SINGLE_DES  1'b1
`define DEF_LINEAR_N    1'b1
`define DEF_PARITY_ODD  1'b0

// ==========================================================
// bit positions inside MODE_PIN_FLOAT
`define FLOAT_FLOW      0
`define FLOAT_DESEL     1
`define FLOAT_ORDER     2
`define FLOAT_W         3

`endif

// [logic/sram_port_pkg.sv]
// types shared by the burst memory port modules
package sram_port_pkg;

	// ==========================================================
	// selection state, one-hot
	typedef enum logic [1:0]
	{
		ST_DESEL = 2'b01,
		ST_SEL   = 2'b10
	} sel_state_t;

	// ==========================================================
	// resolved static mode settings
	typedef struct packed
	{
		logic parity_odd;
		logic flow_n;
		logic single_des;
		logic linear_n;
	} mode_t;

endpackage : sram_port_pkg

// [logic/burst_counter.sv]
// two-bit burst address counter with linear and interleaved order
`include "sram_port_map.svh"
module burst_counter
	import sram_port_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire logic                load,
	input  wire logic                step,
	input  wire logic [`BURST_W-1:0] load_low,
	input  wire logic                linear,
	output logic      [`BURST_W-1:0] low_addr,
	output logic      [`BURST_W-1:0] cnt_q,
	output logic      [`BURST_W-1:0] base_q
);

	typedef struct packed
	{
		logic [`BURST_W-1:0] base;
		logic [`BURST_W-1:0] cnt;
	} ctr_t;

	ctr_t ctr_r;
	ctr_t ctr_nxt;
	logic [`BURST_W-1:0] cnt_inc;

	// ==========================================================
	// order function: the two-bit width wraps the linear sum modulo four
	function automatic logic [`BURST_W-1:0] order(input logic [`BURST_W-1:0] b,
		input logic [`BURST_W-1:0] c, input logic lin);
		order = lin ? b + c : b ^ c;
	endfunction : order

	// ==========================================================
	// next state and the low address bits for this cycle
	always_comb
	begin
		ctr_nxt  = ctr_r;
		cnt_inc  = ctr_r.cnt + 2'h1;
		low_addr = order(ctr_r.base, ctr_r.cnt, linear);
		if (load)
		begin
			ctr_nxt.base = load_low;
			ctr_nxt.cnt  = 2'h0;
			low_addr     = load_low;
		end
		else if (step)
		begin
			ctr_nxt.cnt = cnt_inc;
			low_addr    = order(ctr_r.base, cnt_inc, linear);
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ctr_r <= '0;
		else
			ctr_r <= ctr_nxt;
	end

	assign cnt_q  = ctr_r.cnt;
	assign base_q = ctr_r.base;

endmodule : burst_counter

// [logic/sram_core_array.sv]
// storage array with per-lane write enables and an untimed read port
`include "sram_port_map.svh"
module sram_core_array
	import sram_port_pkg::*;
#(
	parameter int ADDR_W = `ADDR_W_X36,
	parameter int DATA_W = `DATA_W_X36,
	parameter int LANES  = DATA_W / `LANE_W
)
(
	input  wire logic              clk,
	input  wire logic [LANES-1:0]  lane_we,
	input  wire logic [ADDR_W-1:0] waddr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [ADDR_W-1:0] raddr,
	output logic      [DATA_W-1:0] rdata
);

	logic [DATA_W-1:0] mem [2**ADDR_W];

	// ==========================================================
	// no reset on purpose: contents survive sleep and reset alike
	always_ff @(posedge clk)
	begin
		for (int l = 0; l < LANES; l++)
		begin
			if (lane_we[l])
				mem[waddr][l*`LANE_W +: `LANE_W] <= wdata[l*`LANE_W +: `LANE_W];
		end
	end

	assign rdata = mem[raddr];

endmodule : sram_core_array

// [logic/sync_burst_sram_port.sv]
// synchronous burst memory port: control decode, pipeline, deselect and parity check
`include "sram_port_map.svh"
module sync_burst_sram_port
	import sram_port_pkg::*;
#(
	parameter int ADDR_W = `ADDR_W_X36,
	parameter int DATA_W = `DATA_W_X36,
	parameter int LANES  = DATA_W / `LANE_W
)
(
	input  wire logic                 CLK,
	input  wire logic                 RSTN,
	input  wire logic [ADDR_W-1:0]    ADDR,
	input  wire logic [DATA_W-1:0]    DATA_IN,
	input  wire logic                 CHIP_ENABLE_N,
	input  wire logic                 PROCESSOR_ADDR_STROBE_N,
	input  wire logic                 CONTROLLER_ADDR_STROBE_N,
	input  wire logic                 BURST_STEP_N,
	input  wire logic                 ALL_BYTES_WRITE_N,
	input  wire logic                 BYTE_WRITE_GATE_N,
	input  wire logic [LANES-1:0]     BYTE_LANE_WRITE_N,
	input  wire logic                 OUTPUT_ENABLE_N,
	input  wire logic                 SLEEP_REQUEST,
	input  wire logic                 FLOW_THROUGH_SELECT_N,
	input  wire logic                 SINGLE_DESELECT_MODE,
	input  wire logic                 LINEAR_ORDER_SELECT_N,
	input  wire logic                 PARITY_ODD_SELECT,
	input  wire logic [`FLOAT_W-1:0]  MODE_PIN_FLOAT,
	output logic      [DATA_W-1:0]    DATA_OUT,
	output logic                      DATA_OUT_EN_N,
	output logic                      PARITY_ERROR,
	output logic                      SLEEP_ACTIVE
);

	// ==========================================================
	// declarations
	typedef struct packed
	{
		sel_state_t          st;
		logic [ADDR_W-1:0]   addr;
		logic                in_rd;
		logic                in_desel;
		logic                out_rd;
		logic [DATA_W-1:0]   dout;
		logic                perr;
		mode_t               mode1;
		mode_t               mode2;
		logic                slp1;
		logic                slp2;
	} port_t;

	port_t                q_r;
	port_t                q_nxt;
	mode_t                mode_raw;
	logic                 strobe;
	logic                 start;
	logic                 desel_cmd;
	logic                 cont;
	logic                 step;
	logic                 access;
	logic                 is_write;
	logic                 is_read;
	logic [LANES-1:0]     wr_lanes;
	logic [LANES-1:0]     lane_we;
	logic [1:0]           low_addr;
	logic [1:0]           cnt_q;
	logic [1:0]           base_q;
	logic [ADDR_W-1:0]    eff_addr;
	logic [DATA_W-1:0]    rd_data;
	logic [LANES-1:0]     bad_flow;
	logic [LANES-1:0]     bad_pipe;
	logic                 drive;
	logic                 flow;

	// ==========================================================
	// mode pins: a floating pin reads its pull level, then two flops
	always_comb
	begin
		mode_raw.parity_odd = PARITY_ODD_SELECT;
		mode_raw.flow_n     = MODE_PIN_FLOAT[`FLOAT_FLOW] ? `DEF_FLOW_N
			: FLOW_THROUGH_SELECT_N;
		mode_raw.single_des = MODE_PIN_FLOAT[`FLOAT_DESEL] ? `DEF_SINGLE_DES
			: SINGLE_DESELECT_MODE;
		mode_raw.linear_n   = MODE_PIN_FLOAT[`FLOAT_ORDER] ? `DEF_LINEAR_N
			: LINEAR_ORDER_SELECT_N;
	end

	assign flow = ~q_r.mode2.flow_n;

	// ==========================================================
	// command decode; sleep blocks access at once, so nothing is written
	assign strobe    = ~PROCESSOR_ADDR_STROBE_N | ~CONTROLLER_ADDR_STROBE_N;
	assign start     = strobe & ~CHIP_ENABLE_N & ~SLEEP_REQUEST;
	assign desel_cmd = strobe & CHIP_ENABLE_N;
	assign cont      = ~strobe & (q_r.st == ST_SEL) & ~SLEEP_REQUEST;
	assign step      = cont & ~BURST_STEP_N;
	assign access    = start | cont;

	// byte lanes: all-bytes write overrides the gated lane inputs
	assign wr_lanes  = ~ALL_BYTES_WRITE_N ? {LANES{1'b1}}
		: (~BYTE_WRITE_GATE_N ? ~BYTE_LANE_WRITE_N : {LANES{1'b0}});
	assign is_write  = access & (|wr_lanes);
	assign is_read   = access & ~is_write;
	assign lane_we   = is_write ? wr_lanes : {LANES{1'b0}};

	// ==========================================================
	// burst counter touches only the two lowest address bits
	burst_counter u_ctr
	(
		.clk      (CLK),
		.rstn     (RSTN),
		.load     (start),
		.step     (step),
		.load_low (ADDR[1:0]),
		.linear   (~q_r.mode2.linear_n),
		.low_addr (low_addr),
		.cnt_q    (cnt_q),
		.base_q   (base_q)
	);

	assign eff_addr = {(start ? ADDR[ADDR_W-1:2] : q_r.addr[ADDR_W-1:2]), low_addr};

	// writes happen at the sampling edge itself, timed inside
	sram_core_array #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANES(LANES)) u_mem
	(
		.clk     (CLK),
		.lane_we (lane_we),
		.waddr   (eff_addr),
		.wdata   (DATA_IN),
		.raddr   (q_r.addr),
		.rdata   (rd_data)
	);

	// ==========================================================
	// parity per lane, on flow-through data and on the output register
	generate
		for (genvar l = 0; l < LANES; l++)
		begin : g_par
			assign bad_flow[l] = (^rd_data[l*`LANE_W +: `LANE_W]) != q_r.mode2.parity_odd;
			assign bad_pipe[l] = (^q_r.dout[l*`LANE_W +: `LANE_W]) != q_r.mode2.parity_odd;
		end
	endgenerate

	// ==========================================================
	// next state of the whole port
	always_comb
	begin
		q_nxt          = q_r;
		if (start)
			q_nxt.st = ST_SEL;
		else if (desel_cmd)
			q_nxt.st = ST_DESEL;
		if (access)
			q_nxt.addr = eff_addr;
		q_nxt.in_rd    = is_read;
		q_nxt.in_desel = ~access;
		q_nxt.out_rd   = q_r.in_rd;
		q_nxt.dout     = rd_data;
		q_nxt.perr     = flow ? (q_r.in_rd & (|bad_flow))
			: (q_r.out_rd & (|bad_pipe));
		q_nxt.mode1    = mode_raw;
		q_nxt.mode2    = q_r.mode1;
		q_nxt.slp1     = SLEEP_REQUEST;
		q_nxt.slp2     = q_r.slp1;
	end

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			q_r       <= '0;
			q_r.st    <= ST_DESEL;
			q_r.mode1 <= '{`DEF_PARITY_ODD, `DEF_FLOW_N, `DEF_SINGLE_DES, `DEF_LINEAR_N};
			q_r.mode2 <= '{`DEF_PARITY_ODD, `DEF_FLOW_N, `DEF_SINGLE_DES, `DEF_LINEAR_N};
		end
		else
			q_r <= q_nxt;
	end

	// ==========================================================
	// output drive: single deselect cuts a stage short of the read path
	always_comb
	begin
		if (flow)
			drive = q_r.in_rd;
		else if (q_r.mode2.single_des)
			drive = q_r.out_rd & ~q_r.in_desel;
		else
			drive = q_r.out_rd;
	end

	// enable and sleep gate the drivers without a clock, so not registered
	assign DATA_OUT_EN_N = ~(drive & ~OUTPUT_ENABLE_N & ~SLEEP_REQUEST);
	assign DATA_OUT      = flow ? rd_data : q_r.dout;
	assign PARITY_ERROR  = q_r.perr;
	assign SLEEP_ACTIVE  = q_r.slp2;

	// ==========================================================
	// checks
	property p_load;
		@(posedge CLK) disable iff (!RSTN)
		start |=> q_r.addr == $past(ADDR);
	endproperty
	a_load: assert property (p_load) else $error("strobe did not load address");

	property p_hold;
		@(posedge CLK) disable iff (!RSTN)
		(cont & BURST_STEP_N) |=> q_r.addr == $past(q_r.addr);
	endproperty
	a_hold: assert property (p_hold) else $error("address moved without step");

	property p_high;
		@(posedge CLK) disable iff (!RSTN)
		cont |=> q_r.addr[ADDR_W-1:2] == $past(q_r.addr[ADDR_W-1:2]);
	endproperty
	a_high: assert property (p_high) else $error("burst changed high bits");

	property p_order;
		@(posedge CLK) disable iff (!RSTN)
		step |=> q_r.addr[1:0] == (q_r.mode2.linear_n ? (base_q ^ cnt_q)
			: 2'(base_q + cnt_q));
	endproperty
	a_order: assert property (p_order) else $error("burst order wrong");

	property p_pipe;
		@(posedge CLK) disable iff (!RSTN)
		(q_r.in_rd & ~flow & access & $stable(q_r.mode2)) |=> DATA_OUT == $past(rd_data)
			&& DATA_OUT_EN_N == (OUTPUT_ENABLE_N | SLEEP_REQUEST);
	endproperty
	a_pipe: assert property (p_pipe) else $error("pipelined data late");

	property p_flow;
		@(posedge CLK) disable iff (!RSTN)
		(is_read & flow) |=> q_r.addr == $past(eff_addr) && DATA_OUT == rd_data;
	endproperty
	a_flow: assert property (p_flow) else $error("flow data not direct");

	property p_scd;
		@(posedge CLK) disable iff (!RSTN)
		(~flow & q_r.mode2.single_des & ~access) |=> DATA_OUT_EN_N;
	endproperty
	a_scd: assert property (p_scd) else $error("single deselect slow");

	property p_dcd;
		@(posedge CLK) disable iff (!RSTN)
		(~flow & ~q_r.mode2.single_des & is_read ##1 ~access & ~OUTPUT_ENABLE_N
			& ~SLEEP_REQUEST & $stable(q_r.mode2)) |=> ~DATA_OUT_EN_N;
	endproperty
	a_dcd: assert property (p_dcd) else $error("dual deselect fast");

	property p_sleep;
		@(posedge CLK) disable iff (!RSTN)
		SLEEP_REQUEST |-> DATA_OUT_EN_N && lane_we == '0;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not immediate");

	property p_all;
		@(posedge CLK) disable iff (!RSTN)
		(access & ~ALL_BYTES_WRITE_N) |-> &lane_we;
	endproperty
	a_all: assert property (p_all) else $error("all-bytes write partial");

	property p_lane;
		@(posedge CLK) disable iff (!RSTN)
		ALL_BYTES_WRITE_N |-> (lane_we & (BYTE_LANE_WRITE_N | {LANES{BYTE_WRITE_GATE_N}}))
			== '0;
	endproperty
	a_lane: assert property (p_lane) else $error("lane written ungated");

	// covers: burst with a held step, write turnaround, deselect, flow burst, parity
	c_burst:  cover property (@(posedge CLK) disable iff (!RSTN)
		start ##1 step ##1 (cont & BURST_STEP_N) ##1 step [*2]);
	c_flow:   cover property (@(posedge CLK) disable iff (!RSTN) flow & start ##1 step);
	c_write:  cover property (@(posedge CLK) disable iff (!RSTN) is_write ##1 is_read);
	c_desel:  cover property (@(posedge CLK) disable iff (!RSTN) is_read ##1 desel_cmd);
	c_parity: cover property (@(posedge CLK) disable iff (!RSTN) PARITY_ERROR);

endmodule : sync_burst_sram_port

// [verif/bus_master_model.sv]
// bus master model that drives the synchronous controls and straps of the memory port
`include "sram_port_map.svh"
module bus_master_model
	import sram_port_pkg::*;
#(
	parameter int AW = 6,
	parameter int DW = 36,
	parameter int LN = 4
)
(
	input  wire logic                clk,
	output logic      [AW-1:0]       addr,
	output logic      [DW-1:0]       din,
	output logic                     ce_n,
	output logic                     sp_n,
	output logic                     sc_n,
	output logic                     st_n,
	output logic                     gw_n,
	output logic                     gt_n,
	output logic      [LN-1:0]       bl_n,
	output logic                     oe_n,
	output logic                     slp,
	output logic                     fl_n,
	output logic                     sd,
	output logic                     lo_n,
	output logic                     po,
	output logic      [`FLOAT_W-1:0] flt
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// idle levels at time zero: no strobe, no write, drivers allowed
	initial
	begin
		{ce_n, sp_n, sc_n, st_n, gw_n, gt_n, oe_n, slp} = 8'hfc;
		{bl_n, addr, din} = '1;
		{fl_n, sd, lo_n, po, flt} = 7'h70;
	end

	// ==========================================================
	// one bus cycle: change after the edge, hold until the next edge samples it
	task automatic cyc(input logic p, c, e, s, g, b, input logic [LN-1:0] l,
		input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		sp_n <= p;
		sc_n <= c;
		ce_n <= e;
		st_n <= s;
		gw_n <= g;
		gt_n <= b;
		bl_n <= l;
		addr <= a;
		// a data bus not written does not keep its last value
		din  <= (!g || !b) ? d : ~din;
	endtask : cyc

	// straps are static; the bench resets after changing them
	task automatic strap(input logic f, s, l, p, input logic [`FLOAT_W-1:0] x);
		@(posedge clk);
		{fl_n, sd, lo_n, po, flt} <= {f, s, l, p, x};
	endtask : strap

	task automatic async_in(input logic o, z);
		@(posedge clk);
		oe_n <= o;
		slp  <= z;
	endtask : async_in
endmodule : bus_master_model

// [verif/tb.sv]
// self-checking testbench for the burst memory port
`include "sram_port_map.svh"
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
	$display("Error at %0t: got %h, expected %h", $time, got, exp); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int AW = 6;
	localparam int DW = 36;
	localparam int LN = 4;
	logic          CLK;
	logic          RSTN;
	logic [AW-1:0] addr;
	logic [DW-1:0] din;
	logic [DW-1:0] dout;
	logic [LN-1:0] bl_n;
	logic [2:0]    flt;
	logic          ce_n, sp_n, sc_n, st_n, gw_n, gt_n, oe_n, slp, fl_n, sd, lo_n, po;
	logic          en_n, perr, sleeping;
	logic [DW-1:0] mem [0:(1<<AW)-1];
	int            bad_count;
	int            n_tests;
	int            i;

	// ==========================================================
	// master model and device
	bus_master_model #(.AW(AW), .DW(DW), .LN(LN)) m
	(
		.clk(CLK), .addr(addr), .din(din), .ce_n(ce_n), .sp_n(sp_n), .sc_n(sc_n),
		.st_n(st_n), .gw_n(gw_n), .gt_n(gt_n), .bl_n(bl_n), .oe_n(oe_n), .slp(slp),
		.fl_n(fl_n), .sd(sd), .lo_n(lo_n), .po(po), .flt(flt)
	);
	sync_burst_sram_port #(.ADDR_W(AW), .DATA_W(DW), .LANES(LN)) uut
	(
		.CLK(CLK), .RSTN(RSTN), .ADDR(addr), .DATA_IN(din), .CHIP_ENABLE_N(ce_n),
		.PROCESSOR_ADDR_STROBE_N(sp_n), .CONTROLLER_ADDR_STROBE_N(sc_n),
		.BURST_STEP_N(st_n), .ALL_BYTES_WRITE_N(gw_n), .BYTE_WRITE_GATE_N(gt_n),
		.BYTE_LANE_WRITE_N(bl_n), .OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(slp),
		.FLOW_THROUGH_SELECT_N(fl_n), .SINGLE_DESELECT_MODE(sd),
		.LINEAR_ORDER_SELECT_N(lo_n), .PARITY_ODD_SELECT(po), .MODE_PIN_FLOAT(flt),
		.DATA_OUT(dout), .DATA_OUT_EN_N(en_n), .PARITY_ERROR(perr), .SLEEP_ACTIVE(sleeping)
	);

	initial
	begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end

	// ==========================================================
	// word whose lanes each carry even parity
	function automatic logic [DW-1:0] wd(input int s);
		logic [7:0] b;
		wd = '0;
		for (int l = 0; l < LN; l++)
		begin
			b = 8'(s * 37 + l * 11);
			wd[9*l +: 9] = {^b, b};
		end
	endfunction : wd

	// straps change only under reset, so every mode switch resets again
	task automatic rst(input logic f, s, l, p, input logic [2:0] x);
		m.strap(f, s, l, p, x);
		RSTN <= 1'b0;
		repeat (16) @(posedge CLK);
		RSTN <= 1'b1;
		repeat (2) @(posedge CLK);
	endtask : rst

	task automatic idle();
		m.cyc(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, '1, '0, '0);
	endtask : idle

	task automatic wr(input int a, input logic g, b, input logic [LN-1:0] l,
		input logic [DW-1:0] d);
		m.cyc(1'b0, 1'b1, 1'b0, 1'b1, g, b, l, AW'(a), d);
		for (int k = 0; k < LN; k++)
			if (!g || (!b && !l[k]))
				mem[a][9*k +: 9] = d[9*k +: 9];
	endtask : wr

	// single read: data after lat edges, parity flag one edge later
	task automatic rd(input int a, input int lat, input logic pe);
		m.cyc(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, '1, AW'(a), '0);
		repeat (lat) idle();
		#2;
		`CHECK(dout, mem[a]);
		`CHECK(en_n, 1'b0);
		idle();
		#2;
		`CHECK(perr, pe);
	endtask : rd

	// burst of four with one held step in the middle
	task automatic burst(input int a, input logic lin, input int lat);
		int         cn[5] = '{0, 1, 1, 2, 3};
		logic [5:0] st = 6'b110010;
		int         e;
		m.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, '1, AW'(a), '0);
		for (int j = 1; j <= 4 + lat; j++)
		begin
			m.cyc(1'b1, 1'b1, 1'b0, st[j-1], 1'b1, 1'b1, '1, '0, '0);
			#2;
			if (j >= lat)
			begin
				e = lin ? ((a + cn[j-lat]) % 4) : ((a % 4) ^ cn[j-lat]);
				`CHECK(dout, mem[(a & ~3) | e]);
			end
		end
	endtask : burst

	// read then deselect at once; dual mode drives one edge longer
	task automatic ds(input int a, input logic dual);
		m.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, '1, AW'(a), '0);
		m.cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, '1, '0, '0);
		idle();
		#2;
		`CHECK(en_n, ~dual);
		if (dual) `CHECK(dout, mem[a]);
		idle();
		#2;
		`CHECK(en_n, 1'b1);
	endtask : ds

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	// ==========================================================
	// main sequence
	initial
	begin
		RSTN = 1'b0;
		bad_count = 0;
		n_tests = 0;
		rst(1'b1, 1'b1, 1'b1, 1'b0, '0);
		for (i = 0; i < 12; i++)
			wr(i, 1'b0, 1'b1, '1, wd(i));
		wr(3, 1'b1, 1'b0, 4'b1010, wd(99));
		wr(2, 1'b1, 1'b1, 4'b0000, wd(77));
		wr(9, 1'b0, 1'b1, '1, wd(9) ^ 36'h1);
		for (i = 0; i < 4; i++)
			rd(i, 2, 1'b0);
		rd(9, 2, 1'b1);
		burst(5, 1'b0, 2);
		ds(4, 1'b0);
		// keep a read streaming so the drivers are on when the async pins move
		m.cyc(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, '1, AW'(4), '0);
		idle();
		m.async_in(1'b1, 1'b0);
		#2;
		`CHECK(en_n, 1'b1);
		m.async_in(1'b0, 1'b0);
		#2;
		`CHECK(en_n, 1'b0);
		m.async_in(1'b0, 1'b1);
		#2;
		`CHECK(en_n, 1'b1);
		// write attempt while asleep must leave the word alone
		m.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, '1, '0, ~mem[0]);
		idle();
		idle();
		#2;
		`CHECK(sleeping, 1'b1);
		m.async_in(1'b0, 1'b0);
		repeat (3) idle();
		rd(0, 2, 1'b0);
		rst(1'b1, 1'b0, 1'b0, 1'b0, '0);
		burst(5, 1'b1, 2);
		ds(4, 1'b1);
		rst(1'b0, 1'b1, 1'b1, 1'b0, '0);
		rd(1, 1, 1'b0);
		burst(6, 1'b0, 1);
		rst(1'b0, 1'b0, 1'b0, 1'b1, 3'b111);
		rd(0, 2, 1'b1);
		burst(7, 1'b0, 2);
		ds(4, 1'b0);
		complete_run();
	end

	// hang guard: the whole sequence needs well under this span
	initial
	begin
		#50000;
		bad_count++;
		complete_run();
	end
endmodule : tb
